// *** src/sfi_flag_unit.sv ***
// Status flag instruction execution unit: owns the processor flag word and
// updates it, or requests one register-file bit write, in the cycle after issue.
// Assumes the decoder presents op, operands and the source register value
// together with issue_valid; register reads are combinational.
//
`timescale 1ns/1ns

module sfi_flag_unit #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned RIDX_W = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [4:0] op,
  input wire logic [2:0] bit_idx,
  input wire logic [RIDX_W-1:0] reg_idx,
  input wire logic [DATA_W-1:0] src_reg_value,
  input wire logic flag_load_valid,
  input wire logic [7:0] flag_load_value,
  output logic [7:0] processor_flag_word,
  output logic reg_wr_en,
  output logic [RIDX_W-1:0] reg_wr_idx,
  output logic [DATA_W-1:0] reg_wr_data,
  output logic done
);

  if (DATA_W != sfi_pkg::WORD_W) begin : g_bad_data_w
    $error("sfi_flag_unit: register width must equal the flag word width");
  end
  if (RIDX_W < 1) begin : g_bad_ridx_w
    $error("sfi_flag_unit: register index width too small");
  end

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic [7:0] flag_q;
  logic [7:0] flag_d;
  logic reg_wr_en_q;
  logic [RIDX_W-1:0] reg_wr_idx_q;
  logic [DATA_W-1:0] reg_wr_data_q;
  logic done_q;

  sfi_pkg::sfi_op_e op_e;
  logic fixed_hit;
  wire logic gen_hit;
  wire logic bst_hit;
  wire logic bld_hit;
  logic [2:0] fixed_idx;
  logic fixed_val;
  wire logic [2:0] wr_idx;
  wire logic wr_val;
  wire logic src_bit;
  wire logic [7:0] flag_written;
  wire logic [DATA_W-1:0] reg_written;

  assign op_e = sfi_pkg::sfi_op_e'(op);

  // Fixed-flag instructions: map to flag position and value
  always_comb begin
    fixed_hit = 1'b1;
    fixed_idx = 3'h0;
    fixed_val = 1'b0;
    case (op_e)
      sfi_pkg::SFI_OP_RAISE_CARRY: begin
        fixed_idx = 3'(sfi_pkg::FLAG_CARRY);
        fixed_val = 1'b1;
      end
      sfi_pkg::SFI_OP_DROP_CARRY: begin
        fixed_idx = 3'(sfi_pkg::FLAG_CARRY);
      end
      sfi_pkg::SFI_OP_RAISE_NEGATIVE: begin
        fixed_idx = 3'(sfi_pkg::FLAG_NEGATIVE);
        fixed_val = 1'b1;
      end
      sfi_pkg::SFI_OP_DROP_NEGATIVE: begin
        fixed_idx = 3'(sfi_pkg::FLAG_NEGATIVE);
      end
      sfi_pkg::SFI_OP_RAISE_ZERO: begin
        fixed_idx = 3'(sfi_pkg::FLAG_ZERO);
        fixed_val = 1'b1;
      end
      sfi_pkg::SFI_OP_DROP_ZERO: begin
        fixed_idx = 3'(sfi_pkg::FLAG_ZERO);
      end
      sfi_pkg::SFI_OP_RAISE_INTERRUPT_ENABLE: begin
        fixed_idx = 3'(sfi_pkg::FLAG_INT_ENABLE);
        fixed_val = 1'b1;
      end
      sfi_pkg::SFI_OP_DROP_INTERRUPT_ENABLE: begin
        fixed_idx = 3'(sfi_pkg::FLAG_INT_ENABLE);
      end
      sfi_pkg::SFI_OP_RAISE_SIGNED: begin
        fixed_idx = 3'(sfi_pkg::FLAG_SIGNED);
        fixed_val = 1'b1;
      end
      sfi_pkg::SFI_OP_DROP_SIGNED: begin
        fixed_idx = 3'(sfi_pkg::FLAG_SIGNED);
      end
      sfi_pkg::SFI_OP_RAISE_OVERFLOW: begin
        fixed_idx = 3'(sfi_pkg::FLAG_OVERFLOW);
        fixed_val = 1'b1;
      end
      sfi_pkg::SFI_OP_DROP_OVERFLOW: begin
        fixed_idx = 3'(sfi_pkg::FLAG_OVERFLOW);
      end
      sfi_pkg::SFI_OP_RAISE_TRANSFER_BIT: begin
        fixed_idx = 3'(sfi_pkg::FLAG_TRANSFER);
        fixed_val = 1'b1;
      end
      sfi_pkg::SFI_OP_DROP_TRANSFER_BIT: begin
        fixed_idx = 3'(sfi_pkg::FLAG_TRANSFER);
      end
      sfi_pkg::SFI_OP_RAISE_HALF_CARRY: begin
        fixed_idx = 3'(sfi_pkg::FLAG_HALF_CARRY);
        fixed_val = 1'b1;
      end
      sfi_pkg::SFI_OP_DROP_HALF_CARRY: begin
        fixed_idx = 3'(sfi_pkg::FLAG_HALF_CARRY);
      end
      default: begin
        fixed_hit = 1'b0;
      end
    endcase
  end

  assign gen_hit = (op_e == sfi_pkg::SFI_OP_STATUS_BIT_RAISE)
                 || (op_e == sfi_pkg::SFI_OP_STATUS_BIT_DROP);
  assign bst_hit = (op_e == sfi_pkg::SFI_OP_COPY_REG_BIT_TO_TRANSFER);
  assign bld_hit = (op_e == sfi_pkg::SFI_OP_COPY_TRANSFER_TO_REG_BIT);

  // ------------------------------------------------------------
  // Flag word update
  // ------------------------------------------------------------
  sfi_bit_mux #(
    .WIDTH(DATA_W),
    .IDX_W(3)
  ) u_src_sel (
    .word(src_reg_value),
    .idx(bit_idx),
    .bit_out(src_bit)
  );

  // Index and value chosen per instruction class
  assign wr_idx = gen_hit ? bit_idx
                : bst_hit ? 3'(sfi_pkg::FLAG_TRANSFER)
                : fixed_idx;
  assign wr_val = gen_hit ? (op_e == sfi_pkg::SFI_OP_STATUS_BIT_RAISE)
                : bst_hit ? src_bit
                : fixed_val;

  sfi_bit_write #(
    .WIDTH(8),
    .IDX_W(3)
  ) u_flag_wr (
    .word_in(flag_q),
    .idx(wr_idx),
    .value(wr_val),
    .word_out(flag_written)
  );

  wire logic flag_op;
  wire logic load_ok;
  assign flag_op = issue_valid && (gen_hit || bst_hit || fixed_hit);

  // Instruction execution wins over an external flag load in the same cycle;
  // a register bit write leaves the flag word alone, so its load is dropped too
  assign load_ok = flag_load_valid && !(issue_valid && bld_hit);
  assign flag_d = flag_op ? flag_written
                : load_ok ? flag_load_value
                : flag_q;

  // ------------------------------------------------------------
  // Register bit write from the transfer flag
  // ------------------------------------------------------------
  sfi_bit_write #(
    .WIDTH(DATA_W),
    .IDX_W(3)
  ) u_reg_wr (
    .word_in(src_reg_value),
    .idx(bit_idx),
    .value(flag_q[sfi_pkg::FLAG_TRANSFER]),
    .word_out(reg_written)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_q <= sfi_pkg::FLAG_WORD_RESET;
      reg_wr_en_q <= 1'b0;
      reg_wr_idx_q <= '0;
      reg_wr_data_q <= '0;
      done_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      reg_wr_en_q <= issue_valid && bld_hit;
      if (issue_valid && bld_hit) begin
        reg_wr_idx_q <= reg_idx;
        reg_wr_data_q <= reg_written;
      end
      done_q <= issue_valid && (flag_op || bld_hit);
    end
  end

  assign processor_flag_word = flag_q;
  assign reg_wr_en = reg_wr_en_q;
  assign reg_wr_idx = reg_wr_idx_q;
  assign reg_wr_data = reg_wr_data_q;
  assign done = done_q;

endmodule : sfi_flag_unit

// *** shared/sfi_pkg.sv ***
// Constants and types for the status flag instruction unit.
// Assumes a single core clock and synchronous active-low reset.
package sfi_pkg;

  // ------------------------------------------------------------
  // Flag positions within the processor flag word
  // ------------------------------------------------------------
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_ZERO = 1;
  localparam int unsigned FLAG_NEGATIVE = 2;
  localparam int unsigned FLAG_OVERFLOW = 3;
  localparam int unsigned FLAG_SIGNED = 4;
  localparam int unsigned FLAG_HALF_CARRY = 5;
  localparam int unsigned FLAG_TRANSFER = 6;
  localparam int unsigned FLAG_INT_ENABLE = 7;

  localparam int unsigned WORD_W = 8;
  localparam int unsigned BIT_IDX_W = 3;
  localparam int unsigned REG_IDX_W = 5;
  localparam logic [7:0] FLAG_WORD_RESET = 8'h00;

  // ------------------------------------------------------------
  // Operation codes delivered by the instruction decoder
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    SFI_OP_NONE = 5'h00,
    SFI_OP_STATUS_BIT_RAISE = 5'h01,
    SFI_OP_STATUS_BIT_DROP = 5'h02,
    SFI_OP_COPY_REG_BIT_TO_TRANSFER = 5'h03,
    SFI_OP_COPY_TRANSFER_TO_REG_BIT = 5'h04,
    SFI_OP_RAISE_CARRY = 5'h05,
    SFI_OP_DROP_CARRY = 5'h06,
    SFI_OP_RAISE_NEGATIVE = 5'h07,
    SFI_OP_DROP_NEGATIVE = 5'h08,
    SFI_OP_RAISE_ZERO = 5'h09,
    SFI_OP_DROP_ZERO = 5'h0A,
    SFI_OP_RAISE_INTERRUPT_ENABLE = 5'h0B,
    SFI_OP_DROP_INTERRUPT_ENABLE = 5'h0C,
    SFI_OP_RAISE_SIGNED = 5'h0D,
    SFI_OP_DROP_SIGNED = 5'h0E,
    SFI_OP_RAISE_OVERFLOW = 5'h0F,
    SFI_OP_DROP_OVERFLOW = 5'h10,
    SFI_OP_RAISE_TRANSFER_BIT = 5'h11,
    SFI_OP_DROP_TRANSFER_BIT = 5'h12,
    SFI_OP_RAISE_HALF_CARRY = 5'h13,
    SFI_OP_DROP_HALF_CARRY = 5'h14
  } sfi_op_e;

endpackage : sfi_pkg

// *** src/sfi_bit_mux.sv ***
// Selects one bit of a word by index.
// Assumes the index is always within the word.
`timescale 1ns/1ns
module sfi_bit_mux #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned IDX_W = 3
) (
  input wire logic [WIDTH-1:0] word,
  input wire logic [IDX_W-1:0] idx,
  output logic bit_out
);

  if ((1 << IDX_W) != WIDTH) begin : g_bad_width
    $error("sfi_bit_mux: index width does not match word width");
  end

  assign bit_out = word[idx];

endmodule : sfi_bit_mux

// *** src/sfi_bit_write.sv ***
// Forces one bit of a word to a given value, passing the rest through.
// Assumes the index is always within the word.
`timescale 1ns/1ns
module sfi_bit_write #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned IDX_W = 3
) (
  input wire logic [WIDTH-1:0] word_in,
  input wire logic [IDX_W-1:0] idx,
  input wire logic value,
  output logic [WIDTH-1:0] word_out
);

  if ((1 << IDX_W) != WIDTH) begin : g_bad_width
    $error("sfi_bit_write: index width does not match word width");
  end

  wire logic [WIDTH-1:0] sel_mask;

  assign sel_mask = {{(WIDTH-1){1'b0}}, 1'b1} << idx;
  assign word_out = value ? (word_in | sel_mask) : (word_in & ~sel_mask);

endmodule : sfi_bit_write

// *** verif/sfi_flag_unit_sva.sv ***
// Assertions on the ports of the status flag instruction unit.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sfi_flag_unit_sva #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned RIDX_W = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [4:0] op,
  input wire logic [2:0] bit_idx,
  input wire logic [RIDX_W-1:0] reg_idx,
  input wire logic [DATA_W-1:0] src_reg_value,
  input wire logic flag_load_valid,
  input wire logic [7:0] flag_load_value,
  input wire logic [7:0] processor_flag_word,
  input wire logic reg_wr_en,
  input wire logic [RIDX_W-1:0] reg_wr_idx,
  input wire logic [DATA_W-1:0] reg_wr_data,
  input wire logic done
);
  // ------------------------------------------------------------
  // Expected values from the issue cycle
  // ------------------------------------------------------------
  wire logic known_op = issue_valid && op >= 5'h01 && op <= 5'h14;
  wire logic is_fixed = issue_valid && op >= 5'h05 && op <= 5'h14;
  wire logic is_copy = issue_valid && op == 5'h04;
  wire logic [7:0] idx_mask = 8'h01 << bit_idx;
  wire logic [4:0] pair = (op - 5'h05) >> 1;
  wire logic [23:0] pos_tab = {3'h5, 3'h6, 3'h3, 3'h4, 3'h7, 3'h1, 3'h2, 3'h0};
  wire logic [7:0] fix_mask = 8'h01 << pos_tab[pair[2:0] * 3 +: 3];
  wire logic src_bit = src_reg_value[bit_idx];
  wire logic [DATA_W-1:0] bit_mask = DATA_W'(1) << bit_idx;
  wire logic [DATA_W-1:0] copy_data = (src_reg_value & ~bit_mask) |
    (DATA_W'(processor_flag_word[6]) << bit_idx);

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_generic_raise: assert property (issue_valid && op == 5'h01 |=>
    processor_flag_word == ($past(processor_flag_word) | $past(idx_mask)))
    else $error("generic raise wrong");
  a_generic_drop: assert property (issue_valid && op == 5'h02 |=>
    processor_flag_word == ($past(processor_flag_word) & ~$past(idx_mask)))
    else $error("generic drop wrong");
  a_to_transfer: assert property (issue_valid && op == 5'h03 |=>
    processor_flag_word[6] == $past(src_bit) &&
    ((processor_flag_word ^ $past(processor_flag_word)) & 8'hBF) == 8'h00)
    else $error("copy to transfer wrong");
  a_to_reg_bit: assert property (is_copy |=> reg_wr_en &&
    reg_wr_idx == $past(reg_idx) && reg_wr_data == $past(copy_data) &&
    $stable(processor_flag_word)) else $error("copy to register wrong");
  a_fixed_raise: assert property (is_fixed && op[0] |=>
    processor_flag_word == ($past(processor_flag_word) | $past(fix_mask)))
    else $error("fixed raise wrong");
  a_fixed_drop: assert property (is_fixed && !op[0] |=>
    processor_flag_word == ($past(processor_flag_word) & ~$past(fix_mask)))
    else $error("fixed drop wrong");
  a_done_next: assert property (known_op |=> done)
    else $error("done missing");
  a_done_cause: assert property (done |-> $past(known_op))
    else $error("done without issue");
  a_write_cause: assert property (reg_wr_en |-> $past(is_copy))
    else $error("stray register write");
  a_idle_hold: assert property (!issue_valid && !flag_load_valid |=>
    $stable(processor_flag_word)) else $error("flag word moved while idle");
endmodule : sfi_flag_unit_sva

bind sfi_flag_unit sfi_flag_unit_sva #(.DATA_W(DATA_W), .RIDX_W(RIDX_W)) chk_u (
  .clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .op(op), .bit_idx(bit_idx),
  .reg_idx(reg_idx), .src_reg_value(src_reg_value), .flag_load_valid(flag_load_valid),
  .flag_load_value(flag_load_value), .processor_flag_word(processor_flag_word),
  .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .done(done));

// *** verif/sfi_flag_unit_tb_top.sv ***
// Self-checking bench for the status flag instruction unit.
// Assumes each taken instruction answers one cycle later.
`timescale 1ns/1ns
module sfi_flag_unit_tb_top;
  logic clock, rst_n, issue_valid, flag_load_valid, reg_wr_en, done;
  logic [4:0] op, reg_idx, reg_wr_idx;
  logic [2:0] bit_idx;
  logic [7:0] src_reg_value, flag_load_value, processor_flag_word, reg_wr_data, model_q;
  logic [31:0] rnd = 32'h00012297;
  logic [12:0] last_w;
  logic [21:0] expq[$];
  logic [21:0] e;
  localparam logic [2:0] FPOS [8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  sfi_flag_unit dut_u (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .op(op),
    .bit_idx(bit_idx), .reg_idx(reg_idx), .src_reg_value(src_reg_value),
    .flag_load_valid(flag_load_valid), .flag_load_value(flag_load_value),
    .processor_flag_word(processor_flag_word), .reg_wr_en(reg_wr_en),
    .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .done(done));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // Drives one instruction and notes its expected answer
  task automatic run_op(input logic [4:0] o, input logic ld);
    logic [7:0] m;
    logic [2:0] p;
    @(posedge clock);
    rnd = xs(rnd);
    issue_valid <= 1'b1;
    op <= o;
    bit_idx <= rnd[2:0];
    reg_idx <= rnd[7:3];
    src_reg_value <= rnd[15:8];
    flag_load_valid <= ld;
    flag_load_value <= rnd[23:16];
    m = 8'h01 << rnd[2:0];
    p = FPOS[3'((o - 5'h05) >> 1)];
    case (o)
      5'h01: model_q |= m;
      5'h02: model_q &= ~m;
      5'h03: model_q[6] = rnd[8 + rnd[2:0]];
      5'h04: last_w = {rnd[7:3], (rnd[15:8] & ~m) | (model_q[6] ? m : 8'h00)};
      default: if (o > 5'h04 && o < 5'h15) model_q[p] = o[0];
    endcase
    if (o > 5'h00 && o < 5'h15) expq.push_back({o == 5'h04, last_w, model_q});
  endtask : run_op

  task automatic idle_load();
    @(posedge clock);
    rnd = xs(rnd);
    issue_valid <= 1'b0;
    flag_load_valid <= 1'b1;
    flag_load_value <= rnd[7:0];
    model_q = rnd[7:0];
    @(posedge clock);
    flag_load_valid <= 1'b0;
  endtask : idle_load

  // ------------------------------------------------------------
  // Result watcher and timeout
  // ------------------------------------------------------------
  always @(negedge clock) begin
    if (done === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : 'x;
      check(22'(processor_flag_word), 22'(e[7:0]));
      check(22'({reg_wr_en, reg_wr_idx, reg_wr_data}), 22'(e[21:8]));
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, issue_valid, flag_load_valid, op, bit_idx, reg_idx} = '0;
    {src_reg_value, flag_load_value, model_q, last_w} = '0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check(22'({reg_wr_en, reg_wr_idx, reg_wr_data, processor_flag_word}), 22'h0);
    for (int r = 0; r < 3; r++) begin
      for (int o = 0; o < 24; o++) run_op(5'(o), r == 1 && o > 0 && o < 21);
      idle_load();
    end
    @(posedge clock);
    rst_n <= 1'b0;
    issue_valid <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    model_q = 8'h00;
    last_w = 13'h0;
    @(negedge clock);
    check(22'(processor_flag_word), 22'h0);
    for (int i = 0; i < 400; i++) run_op(5'(rnd[12:8] % 5'd20 + 5'd1), rnd[27]);
    @(posedge clock);
    issue_valid <= 1'b0;
    flag_load_valid <= 1'b0;
    repeat (2) @(posedge clock);
    check(22'(expq.size()), 22'h0);
    results();
  end
endmodule : sfi_flag_unit_tb_top
